// *** flash_command_host.sv ***
// Host controller that issues command sequences to a parallel boot-sector flash
`timescale 1ns/1ps
// Rules from the document
// RL1 - Command data only in low byte
// RL2 - Command addresses on low eleven bits
// RL3 - Sixth erase cycle carries sector number
// RL4 - Protect verify: read with sector upper bits
// RL5 - Suspend only during sector erase; host only checks that it is not already suspended
// RL6 - Resume only while suspended
// RL7 - Read/reset only in ID or timeout; host issues it whenever idle and device ready
// RL8 - Read/reset aborts erase before start
// RL9 - Read/reset aborts program before start
// RL10 - Read/reset aborts or exits ID mode
// RL11 - Program: two unlocks, setup, data
// RL12 - Commands ignored while algorithm runs
// RL13 - Hardware reset aborts; reissue afterwards
// RL14 - Program cannot set zero to one
// RL15 - Chip erase six-cycle sequence
// RL16 - Only selected unprotected sectors erased
// RL17 - Extra sectors spaced under window
// RL18 - Extra sector cycles issued without pause
// RL19 - Extra sector by six or three cycles; host sends three or one
// RL20 - All-protected erase returns after 100 us
// RL21 - Window-expired status bit readable
// RL22 - Other command in window resets
// RL23 - Bad cycle returns to read mode
// RL24 - Advance only on completed write edge
module flash_command_host
  import flash_host_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        op_valid,
  input  wire logic [2:0]  op_code,
  input  wire logic [17:0] op_addr,
  input  wire logic [15:0] op_data,
  input  wire logic        op_short,
  output logic             op_ready,
  output logic             op_done,
  output logic             suspended,
  output logic [15:0]      rd_data,
  output logic [17:0]      fl_addr,
  output logic [15:0]      fl_dq_out,
  output logic             fl_dq_oe,
  input  wire logic [15:0] fl_dq_in,
  output logic             fl_ce_n,
  output logic             fl_we_n,
  output logic             fl_oe_n,
  output logic             fl_reset_n,
  input  wire logic        fl_ready
);
  import flash_host_pkg::*;
  typedef enum {S_RESET, S_IDLE, S_CYCLE, S_DONE} state_t;
  state_t      state_q;
  logic [2:0]  idx_q;
  logic [2:0]  last_q;
  logic [2:0]  op_q;
  logic [17:0] addr_q;
  logic [15:0] data_q;
  logic [1:0]  ph_q;
  logic [15:0] cnt_q;
  logic        susp_q;
  logic        ready_q;
  logic        done_q;
  logic [15:0] rdat_q;
  logic [17:0] fa_q;
  logic [15:0] fd_q;
  logic        oe_q;
  logic        ce_q;
  logic        we_q;
  logic        rd_q;
  logic        rst_n_q;
  //////////////////////////////////////////////////////////////////////////////
  // Sequence tables
  function automatic logic [2:0] seq_len(input logic [2:0] op, input logic sh);
    case (op)
      OP_PROGRAM:      seq_len = 3'd4;
      OP_CHIP_ERASE:   seq_len = 3'd6;
      OP_SECTOR_ERASE: seq_len = 3'd6;
      OP_ADD_SECTOR:   seq_len = sh ? 3'd3 : 3'd1;
      OP_IDENT:        seq_len = 3'd4;
      default:         seq_len = 3'd1;
    endcase
  endfunction
  wire [2:0]  idx_eff = (op_q == OP_ADD_SECTOR && last_q == 3'd3) ? idx_q + 3'd3 :
                        (op_q == OP_ADD_SECTOR) ? 3'd5 :
                        (op_q == OP_SUSPEND || op_q == OP_RESUME ||
                         op_q == OP_READ_RESET) ? 3'd7 : idx_q;
  // Second unlock pair belongs to the six-cycle erase forms and the three-cycle extra sector form
  wire        six_cyc = (op_q == OP_CHIP_ERASE || op_q == OP_SECTOR_ERASE ||
                         op_q == OP_ADD_SECTOR);
  wire        unl_a   = (idx_eff == 3'd0) || (six_cyc && idx_eff == 3'd3);
  wire        unl_b   = (idx_eff == 3'd1) || (six_cyc && idx_eff == 3'd4);
  // Command bytes sit in the low lane; upper lane driven zero [RL1]
  wire [7:0]  cmd_byte = (op_q == OP_PROGRAM)  ? CMD_PROGRAM :
                         (op_q == OP_IDENT)    ? CMD_IDENT : CMD_ERASE;
  wire [7:0]  last_byte = (op_q == OP_CHIP_ERASE) ? CMD_CHIP_ERASE : CMD_SECTOR_ERASE; // [RL15]
  wire [7:0]  one_byte  = (op_q == OP_SUSPEND) ? CMD_SUSPEND :
                          (op_q == OP_RESUME)  ? CMD_RESUME : CMD_RESET;
  wire [15:0] cyc_data = unl_a ? {8'h00, UNLOCK1_DATA} :
                         unl_b ? {8'h00, UNLOCK2_DATA} :
                         (idx_eff == 3'd2) ? {8'h00, cmd_byte} :
                         (idx_eff == 3'd7) ? {8'h00, one_byte} :
                         (op_q == OP_PROGRAM) ? data_q : {8'h00, last_byte}; // [RL11]
  // Sector number rides on upper bits in the final erase cycle [RL3] [RL19]
  wire [17:0] sect_addr = {addr_q[17:SECT_LSB], 12'h000};
  wire [17:0] cyc_addr = unl_a ? {7'h00, UNLOCK1_ADDR} :                    // [RL2]
                         unl_b ? {7'h00, UNLOCK2_ADDR} :
                         (idx_eff == 3'd2) ? {7'h00, UNLOCK1_ADDR} :
                         (idx_eff == 3'd7) ? 18'h00000 :
                         (op_q == OP_PROGRAM) ? addr_q :
                         (op_q == OP_IDENT) ? {addr_q[17:SECT_LSB], 4'h0, PROT_VERIFY_LOW} :
                         (op_q == OP_CHIP_ERASE) ? {7'h00, UNLOCK1_ADDR} : sect_addr;
  // Fourth ID cycle is a read of protection status [RL4]
  wire        is_read  = (op_q == OP_IDENT) && (idx_q == 3'd3);
  // Suspend only when not yet suspended; resume only when suspended [RL5] [RL6]
  wire        op_legal = (op_code == OP_RESUME) ? susp_q :
                         (op_code == OP_SUSPEND) ? !susp_q : 1'b1;
  // Device ignores commands while busy, so wait for ready except suspend [RL12]
  wire        can_go   = fl_ready || (op_code == OP_SUSPEND);
  wire        take     = (state_q == S_IDLE) && op_valid && op_legal && can_go;
  wire        ph_end   = (cnt_q == 16'(STROBE_CYC - 1));
  wire        cyc_end  = (ph_q == PH_HOLD) && ph_end;
  //////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= S_RESET;
      cnt_q   <= 16'h0000;
      rst_n_q <= 1'b0;
      susp_q  <= 1'b0;
      ready_q <= 1'b0;
      done_q  <= 1'b0;
      idx_q   <= 3'd0;
      last_q  <= 3'd0;
      op_q    <= 3'd0;
      addr_q  <= 18'h00000;
      data_q  <= 16'h0000;
      ph_q    <= PH_SETUP;
      rdat_q  <= 16'h0000;
      fa_q    <= 18'h00000;
      fd_q    <= 16'h0000;
      oe_q    <= 1'b0;
      ce_q    <= 1'b1;
      we_q    <= 1'b1;
      rd_q    <= 1'b1;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        S_RESET: begin
          // Pin reset pulse aborts any algorithm; user reissues afterwards [RL13]
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == 16'(RESET_CYC)) begin
            rst_n_q <= 1'b1;
            susp_q  <= 1'b0;
            cnt_q   <= 16'h0000;
            state_q <= S_IDLE;
            ready_q <= 1'b1;
          end
        end
        S_IDLE: begin
          if (take) begin
            op_q    <= op_code;
            addr_q  <= op_addr;
            data_q  <= op_data;
            last_q  <= seq_len(op_code, op_short);
            idx_q   <= 3'd0;
            ph_q    <= PH_SETUP;
            cnt_q   <= 16'h0000;
            ready_q <= 1'b0;
            state_q <= S_CYCLE;
            if (op_code == OP_SUSPEND) susp_q <= 1'b1;
            if (op_code == OP_RESUME)  susp_q <= 1'b0;
            // Read/reset leaves ID mode back into suspend, so only resume, a chip erase or a pin reset clears
            if (op_code == OP_CHIP_ERASE) susp_q <= 1'b0;
          end
        end
        S_CYCLE: begin
          cnt_q <= ph_end ? 16'h0000 : cnt_q + 16'h0001;
          case (ph_q)
            PH_SETUP: begin
              fa_q <= cyc_addr;
              fd_q <= cyc_data;
              oe_q <= !is_read;
              ce_q <= 1'b0;
              if (ph_end) ph_q <= PH_STROBE;
            end
            PH_STROBE: begin
              we_q <= is_read;
              rd_q <= !is_read;
              if (ph_end) ph_q <= PH_HOLD;
            end
            PH_HOLD: begin
              // Rising write edge completes the cycle [RL24]
              we_q <= 1'b1;
              rd_q <= 1'b1;
              if (is_read && cnt_q == 16'h0000) rdat_q <= fl_dq_in;
              if (ph_end) ph_q <= PH_SETUP;
            end
            default: ph_q <= PH_SETUP;
          endcase
          if (cyc_end) begin
            ce_q <= 1'b1;
            oe_q <= 1'b0;
            // Cycles sent back to back, well under the window [RL17] [RL18]
            if (idx_q + 3'd1 == last_q) state_q <= S_DONE;
            else idx_q <= idx_q + 3'd1;
          end
        end
        S_DONE: begin
          done_q  <= 1'b1;
          ready_q <= 1'b1;
          state_q <= S_IDLE;
        end
        default: state_q <= S_RESET;
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign op_ready   = ready_q;
  assign op_done    = done_q;
  assign suspended  = susp_q;
  assign rd_data    = rdat_q;
  assign fl_addr    = fa_q;
  assign fl_dq_out  = fd_q;
  assign fl_dq_oe   = oe_q;
  assign fl_ce_n    = ce_q;
  assign fl_we_n    = we_q;
  assign fl_oe_n    = rd_q;
  assign fl_reset_n = rst_n_q;
endmodule

// *** flash_host_pkg.sv ***
// Constants shared by the flash command host controller
package flash_host_pkg;
  localparam int unsigned CLK_MHZ          = 50;
  localparam logic [10:0] UNLOCK1_ADDR     = 11'h555;
  localparam logic [10:0] UNLOCK2_ADDR     = 11'h2AA;
  localparam logic [7:0]  UNLOCK1_DATA     = 8'hAA;
  localparam logic [7:0]  UNLOCK2_DATA     = 8'h55;
  localparam logic [7:0]  CMD_RESET        = 8'hF0;
  localparam logic [7:0]  CMD_PROGRAM      = 8'hA0;
  localparam logic [7:0]  CMD_ERASE        = 8'h80;
  localparam logic [7:0]  CMD_CHIP_ERASE   = 8'h10;
  localparam logic [7:0]  CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0]  CMD_SUSPEND      = 8'hB0;
  localparam logic [7:0]  CMD_RESUME       = 8'h30;
  localparam logic [7:0]  CMD_IDENT        = 8'h90;
  localparam logic [7:0]  PROT_VERIFY_LOW  = 8'h02;
  localparam int unsigned SECT_LSB         = 12;
  localparam int unsigned WINDOW_US        = 50;
  localparam int unsigned STROBE_NS        = 100;
  localparam int unsigned STROBE_CYC       = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WINDOW_CYC       = (WINDOW_US * CLK_MHZ);
  localparam int unsigned RESET_NS         = 500;
  localparam int unsigned RESET_CYC        = (RESET_NS * CLK_MHZ + 999) / 1000;
  localparam logic [2:0]  OP_PROGRAM       = 3'h0;
  localparam logic [2:0]  OP_CHIP_ERASE    = 3'h1;
  localparam logic [2:0]  OP_SECTOR_ERASE  = 3'h2;
  localparam logic [2:0]  OP_ADD_SECTOR    = 3'h3;
  localparam logic [2:0]  OP_SUSPEND       = 3'h4;
  localparam logic [2:0]  OP_RESUME        = 3'h5;
  localparam logic [2:0]  OP_IDENT         = 3'h6;
  localparam logic [2:0]  OP_READ_RESET    = 3'h7;
  localparam logic [1:0]  PH_SETUP         = 2'h0;
  localparam logic [1:0]  PH_STROBE        = 2'h1;
  localparam logic [1:0]  PH_HOLD          = 2'h2;
endpackage

// *** flash_command_host_chk.sv ***
// Port checker for the flash command host
`timescale 1ns/1ps
module flash_command_host_chk
  import flash_host_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       op_valid,
  input wire logic [2:0] op_code,
  input wire logic       op_ready,
  input wire logic       suspended,
  input wire logic       fl_dq_oe,
  input wire logic       fl_ce_n,
  input wire logic       fl_we_n,
  input wire logic       fl_oe_n,
  input wire logic       fl_reset_n,
  input wire logic       fl_ready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_reset_pin_low: assert property (disable iff (1'b0) rst |=> !fl_reset_n)
    else $error("reset pin not driven low");
  a_write_selected: assert property (!fl_we_n |-> !fl_ce_n)
    else $error("write strobe without chip select");
  a_strobe_exclusive: assert property (!(!fl_we_n && !fl_oe_n))
    else $error("write and read strobes together");
  a_write_drives: assert property (!fl_we_n |-> fl_dq_oe)
    else $error("write strobe with data bus released");
  a_read_releases: assert property (!fl_oe_n |-> !fl_dq_oe)
    else $error("read strobe while host drives data");
  a_strobe_width: assert property ($fell(fl_we_n) |-> !fl_we_n [*5] ##1 fl_we_n)
    else $error("write strobe width wrong");
  a_resume_refused: assert property (op_valid && op_ready && op_code == OP_RESUME
    && !suspended |=> op_ready) else $error("resume taken while not suspended");
  a_busy_refused: assert property (op_valid && op_ready && !fl_ready
    && op_code != OP_SUSPEND |=> op_ready) else $error("request taken while busy");
  a_suspend_flag: assert property (op_valid && op_ready && op_code == OP_SUSPEND
    && !suspended |-> ##[1:40] suspended) else $error("suspend flag not set");
endmodule
bind flash_command_host flash_command_host_chk i_chk (.mclk, .rst, .op_valid, .op_code,
  .op_ready, .suspended, .fl_dq_oe, .fl_ce_n, .fl_we_n, .fl_oe_n, .fl_reset_n, .fl_ready);

// *** flash_dev_model.sv ***
// Behavioural flash device facing the host controller
`timescale 1ns/1ps
module flash_dev_model #(
  parameter logic [5:0] PROT_SECT = 6'h2D,
  parameter int         BUSY_NS   = 3005
) (
  input  wire logic [17:0] fl_addr,
  input  wire logic [15:0] fl_dq_out,
  input  wire logic        fl_ce_n,
  input  wire logic        fl_we_n,
  input  wire logic        fl_oe_n,
  input  wire logic        fl_reset_n,
  output logic      [15:0] fl_dq_in,
  output logic             fl_ready
);
  logic [33:0] log[$];
  logic [7:0]  pd = 8'h00;
  logic [15:0] rdv;
  initial fl_ready = 1'b1;
  // Only a finished write with chip selected counts; upper byte ignored
  always @(posedge fl_we_n) begin
    if (!fl_ce_n && fl_reset_n) begin
      log.push_back({fl_addr, fl_dq_out});
      if (pd == 8'hA0 && fl_ready) begin
        fl_ready = 1'b0;
      end
      pd = fl_dq_out[7:0];
    end
  end
  // Busy span is off the clock grid so ready never ties with a clock edge
  always @(negedge fl_ready) begin
    #(BUSY_NS) fl_ready = 1'b1;
  end
  // Hardware reset ends the algorithm at once
  always @(negedge fl_reset_n) begin
    fl_ready = 1'b1;
    pd = 8'h00;
  end
  // Released bus shows the inverse so stale data cannot pass
  assign rdv = (fl_addr[7:0] != 8'h02) ? 16'hFFFF : {15'h0000, fl_addr[17:12] == PROT_SECT};
  assign fl_dq_in = fl_oe_n ? ~rdv : rdv;
endmodule

// *** tb_top.sv ***
// Self-checking bench for the flash command host
`timescale 1ns/1ps
module tb_top;
  import flash_host_pkg::*;
  logic        mclk = 0, rst = 1, op_valid = 0, op_short = 0;
  logic [2:0]  op_code = 0;
  logic [17:0] op_addr = 0, fl_addr;
  logic [15:0] op_data = 0, rd_data, fl_dq_out, fl_dq_in;
  logic        op_ready, op_done, suspended, fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n;
  logic        fl_reset_n, fl_ready;
  int          miscompares = 0, n_tests = 0;
  logic [18:0] ex[$];
  always #10 mclk = ~mclk;
  flash_command_host i_flash_command_host (.mclk, .rst, .op_valid, .op_code, .op_addr,
    .op_data, .op_short, .op_ready, .op_done, .suspended, .rd_data, .fl_addr, .fl_dq_out,
    .fl_dq_oe, .fl_dq_in, .fl_ce_n, .fl_we_n, .fl_oe_n, .fl_reset_n, .fl_ready);
  flash_dev_model i_model (.fl_addr, .fl_dq_out, .fl_ce_n, .fl_we_n, .fl_oe_n,
    .fl_reset_n, .fl_dq_in, .fl_ready);
  ////////////////////////////////////////////////////////////////////////////////
  task cmp(input string nm, input logic [33:0] e, input logic [33:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Waits for the request to be taken, then compares the bus cycles seen
  task op(input logic [2:0] c, input logic [17:0] a, input logic s);
    int b;
    int k;
    b = i_model.log.size();
    @(negedge mclk);
    k = 0;
    while (!op_ready && k < 3000) begin
      @(negedge mclk);
      k++;
    end
    op_code = c;
    op_addr = a;
    op_short = s;
    op_valid = 1;
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (op_ready && k < 3000);
    op_valid = 0;
    cmp("taken", 0, 34'(op_ready));
    k = 0;
    while (!op_done && k < 500) begin
      @(negedge mclk);
      k++;
    end
    cmp("done", 1, 34'(op_done));
    cmp("cycles", 34'(ex.size()), 34'(i_model.log.size() - b));
    foreach (ex[i]) cmp("cycle", 34'(ex[i]), 34'({i_model.log[b+i][26:16],
      i_model.log[b+i][7:0]}));
    $display("op %0d done", c);
  endtask
  task refuse(input logic [2:0] c);
    int b;
    b = i_model.log.size();
    @(negedge mclk);
    op_code = c;
    op_valid = 1;
    repeat (20) @(negedge mclk);
    op_valid = 0;
    cmp("refused", 34'(b), 34'(i_model.log.size()));
    $display("refusal %0d done", c);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(negedge mclk);
    rst = 0;
    op_data = 16'h1234;
    ex = '{19'h555AA, 19'h2AA55, 19'h555A0, 19'h3CD34};
    op(OP_PROGRAM, 18'h2ABCD, 0);
    cmp("prog", {18'h2ABCD, 16'h1234}, i_model.log[$]);
    refuse(OP_IDENT);
    ex = '{19'h555AA, 19'h2AA55, 19'h55580, 19'h555AA, 19'h2AA55, 19'h00030};
    op(OP_SECTOR_ERASE, 18'h2D000, 0);
    cmp("sector", 34'h2D, 34'(i_model.log[$][33:28]));
    ex = '{19'h555AA, 19'h2AA55, 19'h00030};
    op(OP_ADD_SECTOR, 18'h05010, 1);
    cmp("sector", 34'h05, 34'(i_model.log[$][33:28]));
    ex = '{19'h00030};
    op(OP_ADD_SECTOR, 18'h3F000, 0);
    ex = '{19'h000B0};
    op(OP_SUSPEND, 0, 0);
    cmp("susp", 1, 34'(suspended));
    ex = '{19'h555AA, 19'h2AA55, 19'h55590};
    op(OP_IDENT, 18'h2D000, 0);
    cmp("prot", 1, 34'(rd_data));
    op(OP_IDENT, 18'h01000, 0);
    cmp("unprot", 0, 34'(rd_data));
    ex = '{19'h000F0};
    op(OP_READ_RESET, 0, 0);
    cmp("idexit", 1, 34'(suspended));
    ex = '{19'h00030};
    op(OP_RESUME, 0, 0);
    cmp("resumed", 0, 34'(suspended));
    refuse(OP_RESUME);
    ex = '{19'h000F0};
    op(OP_READ_RESET, 0, 0);
    ex = '{19'h555AA, 19'h2AA55, 19'h55580, 19'h555AA, 19'h2AA55, 19'h55510};
    op(OP_CHIP_ERASE, 0, 0);
    ex = '{19'h555AA, 19'h2AA55, 19'h555A0, 19'h3CD34};
    op(OP_PROGRAM, 18'h2ABCD, 0);
    rst = 1;
    repeat (3) @(negedge mclk);
    cmp("rstpin", 0, 34'(fl_reset_n));
    rst = 0;
    op(OP_PROGRAM, 18'h2ABCD, 0);
    end_sim;
  end
  // Whole run needs well under this span
  initial begin
    #400000;
    miscompares++;
    end_sim;
  end
endmodule
